//--- rtl/lpw_wakeup_ctrl.sv
/*
 * wake-up and recovery controller for wait and stop modes, with
 * periodic tick unit, vector fetch and stop recovery counter;
 * assumes the cpu pulses the mode requests, a byte rom answering
 * one cycle after its address, and pclk as the crystal clock
 */
// Behaviour
// - tick runs in wait, register blocked
// - tick runs in stop only with oscillator
// - tick register blocked in stop
// - reset pin ends low power, reset vector
// - irq pin falling edge wakes, irq vector
// - break wakes in emulation, break vector
// - watchdog timeout in wait resets
// - undervoltage reset ends low power
// - clock generator request ends wait
// - keypad request ends wait
// - timer one requests end wait
// - timer two requests end wait
// - spi requests end wait
// - serial unit requests end wait
// - adc conversion complete ends wait
// - tick rollover wakes wait or stop
// - keypad polarity picks stop wake edge
// - stop exit holds clocks 4096 cycles
// - short select gives 32 cycles
// - entry clears mask, reset sets it
`timescale 1ns/1ps
module lpw_wakeup_ctrl
    import lpw_pkg::*;
(
    input wire logic pclk,            // bus and crystal clock
    input wire logic presetn,         // async reset, low
    input wire logic psel,            // apb select
    input wire logic penable,         // apb enable
    input wire logic pwrite,          // apb direction
    input wire logic [11:0] paddr,    // apb address
    input wire logic [31:0] pwdata,   // apb write data
    output logic [31:0] prdata,       // apb read data
    output logic pready,              // apb ready
    output logic pslverr,             // apb error
    input wire logic ext_reset_n,     // reset pin
    input wire logic ext_irq_n,       // interrupt pin
    input wire logic [7:0] kbd_pin,   // keypad pins
    input wire logic emu_mode,        // emulation mode
    input wire logic wait_req,        // cpu enters wait
    input wire logic stop_req,        // cpu enters stop
    input wire logic imask_set,       // cpu sets mask
    input wire logic wdog_timeout,    // watchdog timeout
    input wire logic uv_reset,        // undervoltage reset
    input wire lpw_irq_t irq_in,      // peripheral requests
    input wire logic [7:0] mem_data,  // vector rom data
    output logic [15:0] mem_addr,     // vector rom address
    output logic [15:0] pc_value,     // fetched vector
    output logic pc_load,             // load pc, pulse
    output logic sys_rst,             // device reset
    output logic int_mask,            // cpu interrupt mask
    output logic cpu_clk_en,          // cpu clock gate
    output logic sys_clk_en,          // system clock gate
    output logic tick_irq             // tick pending
);

    typedef enum logic [3:0] {
        ST_RUN, ST_WAIT, ST_STOP, ST_RECOVER,
        ST_FETCH_HI, ST_FETCH_LO, ST_LOAD
    } lpw_state_t;

    lpw_state_t st_reg, st_next;
    logic [31:0] ctrl_reg, ctrl_next;
    logic [31:0] tick_reg, tick_next;
    logic [15:0] tcnt_reg, tcnt_next;
    logic tick_flag_reg, tick_flag_next;
    logic [11:0] rc_reg, rc_next;
    logic [15:0] vec_reg, vec_next;
    logic [7:0] hi_reg, hi_next;
    logic [15:0] addr_reg, addr_next;
    logic [15:0] pc_reg, pc_next;
    logic load_reg, load_next;
    logic rst_reg, rst_next;
    logic imask_reg, imask_next;
    logic cpuen_reg, cpuen_next;
    logic sysen_reg, sysen_next;
    logic [PIN_W-1:0] s1_reg, s2_reg, s3_reg;
    logic [PIN_W-1:0] pinf_reg, pinf_next, pinq_reg;
    logic [31:0] rd_reg, rd_next;
    logic rdy_reg, err_reg, err_next;

    // pick highest priority vector among hits
    function automatic logic [15:0] pick_vec(
        input logic [NSRC-1:0] h);
        logic [15:0] v;
        v = VEC_RESET;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (h[i]) begin
                v = VEC_TAB[i];
            end
        end
        return v;
    endfunction : pick_vec

    // control fields
    wire short_rec = ctrl_reg[CTRL_SHORT_BIT];
    wire osc_run = ctrl_reg[CTRL_OSC_BIT];
    wire [7:0] kpol = ctrl_reg[CTRL_KPOL_LSB+:8];
    wire tick_en = tick_reg[TICK_EN_BIT];
    wire [15:0] tick_per = tick_reg[15:0];

    // mode decode
    wire in_wait = (st_reg == ST_WAIT);
    wire in_stop = (st_reg == ST_STOP);
    wire in_rec = (st_reg == ST_RECOVER);
    wire low_pwr = in_wait | in_stop | in_rec;

    // pin edges from the filtered levels
    wire [PIN_W-1:0] agree = ~(s2_reg ^ s3_reg);
    wire [7:0] k_rise = pinf_reg[7:0] & ~pinq_reg[7:0];
    wire [7:0] k_fall = ~pinf_reg[7:0] & pinq_reg[7:0];
    wire kpin_hit = |((kpol & k_rise) | (~kpol & k_fall));
    wire irq_fall = pinq_reg[PIN_IRQ] & ~pinf_reg[PIN_IRQ];
    wire rst_pin = ~pinf_reg[PIN_RST];

    // reset sources; watchdog has no clock in stop
    wire wdog_hit = wdog_timeout & ~in_stop;
    wire rst_src = rst_pin | uv_reset | wdog_hit;

    // wake source vector in priority order
    wire kbd_req = irq_in.kbd | (in_stop & kpin_hit);
    wire brk_req = irq_in.brk & emu_mode;
    wire [NSRC-1:0] src = {irq_in.t2_hi, tick_flag_reg,
        irq_in.adc, kbd_req, irq_in.serial, irq_in.spi,
        irq_in.t2_lo, irq_in.t1, irq_in.clk_gen,
        irq_fall, brk_req};
    wire [NSRC-1:0] stop_src = src & STOP_WAKE;
    wire wake_w = |src;
    wire wake_s = |stop_src;
    wire [15:0] wake_vec = pick_vec(in_stop ? stop_src : src);

    // tick counter runs unless stop stopped the oscillator
    wire tick_run = tick_en & (osc_run | ~(in_stop | in_rec));
    wire tick_roll = tick_run & (tcnt_reg == tick_per);
    wire tick_ack = (st_next == ST_FETCH_HI) & ~rst_src
        & (vec_next == VEC_TAB[SRC_TICK]);

    // apb decode
    wire setup = psel & ~penable;
    wire acc_wr = psel & penable & rdy_reg & pwrite & ~err_reg;
    wire hit_ctrl = (paddr == ADDR_CTRL);
    wire hit_tick = (paddr == ADDR_TICK);
    wire hit_stat = (paddr == ADDR_STAT);
    wire tick_blk = hit_tick & low_pwr;
    wire bad_addr = ~(hit_ctrl | hit_tick | hit_stat);
    wire bad = bad_addr | tick_blk | (hit_stat & pwrite);
    wire [31:0] stat_val = {pc_reg, 11'h000, imask_reg, st_reg};
    wire [31:0] rd_val = hit_ctrl ? ctrl_reg
        : hit_tick ? tick_reg
        : hit_stat ? stat_val : 32'h0000_0000;

    // apb answer, one access cycle, error on refusal
    assign rd_next = (setup & ~pwrite & ~bad) ? rd_val
        : 32'h0000_0000;
    assign err_next = setup & bad;
    assign ctrl_next = (acc_wr & hit_ctrl) ? pwdata : ctrl_reg;
    assign tick_next = (acc_wr & hit_tick) ? pwdata : tick_reg;

    // tick count and sticky rollover flag, set wins
    assign tcnt_next = ~tick_run ? tcnt_reg
        : tick_roll ? 16'h0000 : 16'(tcnt_reg + 16'h0001);
    assign tick_flag_next = tick_roll
        | (tick_flag_reg & ~tick_ack & ~rst_src);

    // filtered pins follow once stages two and three agree
    assign pinf_next = (agree & s3_reg) | (~agree & pinf_reg);

    // mode sequencing
    always_comb begin
        st_next = st_reg;
        vec_next = vec_reg;
        rc_next = rc_reg;
        imask_next = imask_reg | imask_set;
        unique case (st_reg)
            ST_RUN: begin
                if (stop_req) begin
                    st_next = ST_STOP;
                    imask_next = 1'b0;
                end else if (wait_req) begin
                    st_next = ST_WAIT;
                    imask_next = 1'b0;
                end
            end
            ST_WAIT: begin
                if (wake_w) begin
                    st_next = ST_FETCH_HI;
                    vec_next = wake_vec;
                end
            end
            ST_STOP: begin
                if (wake_s) begin
                    st_next = ST_RECOVER;
                    vec_next = wake_vec;
                end
            end
            ST_RECOVER: begin
                rc_next = 12'(rc_reg - 12'h001);
                if (rc_reg == 12'h000) begin
                    st_next = ST_FETCH_HI;
                end
            end
            ST_FETCH_HI: st_next = ST_FETCH_LO;
            ST_FETCH_LO: st_next = ST_LOAD;
            ST_LOAD: st_next = ST_RUN;
        endcase
        // every stop exit runs the recovery count
        if (in_stop & (wake_s | rst_src)) begin
            rc_next = short_rec ? RECOV_SHORT_LD
                : RECOV_LONG_LD;
        end
        // reset sources override any other event
        if (rst_src) begin
            vec_next = VEC_RESET;
            imask_next = 1'b1;
            if (in_stop) begin
                st_next = ST_RECOVER;
            end else if (~in_rec) begin
                st_next = ST_FETCH_HI;
            end
        end
    end

    // vector fetch, high byte from the lower location
    // a held reset source keeps the fetch on the vector itself
    wire step_lo = (st_reg == ST_FETCH_HI) & (st_next == ST_FETCH_LO);
    assign addr_next = step_lo ? 16'(vec_reg + 16'h0001) : vec_next;
    assign hi_next = (st_reg == ST_FETCH_LO) ? mem_data : hi_reg;
    assign pc_next = (st_reg == ST_LOAD) ? {hi_reg, mem_data}
        : pc_reg;
    assign load_next = (st_reg == ST_LOAD);
    assign rst_next = rst_src;

    // clock gates follow the next mode
    assign cpuen_next = ~(st_next == ST_WAIT | st_next == ST_STOP
        | st_next == ST_RECOVER);
    assign sysen_next = ~(st_next == ST_STOP
        | st_next == ST_RECOVER);

    // pin synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= PIN_IDLE;
            s2_reg <= PIN_IDLE;
            s3_reg <= PIN_IDLE;
            pinf_reg <= PIN_IDLE;
            pinq_reg <= PIN_IDLE;
        end else begin
            s1_reg <= {ext_reset_n, ext_irq_n, kbd_pin};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            pinf_reg <= pinf_next;
            pinq_reg <= pinf_reg;
        end
    end

    // apb registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RST;
            tick_reg <= TICK_RST;
            rd_reg <= 32'h0000_0000;
            rdy_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            tick_reg <= tick_next;
            rd_reg <= rd_next;
            rdy_reg <= setup;
            err_reg <= err_next;
        end
    end

    // tick unit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tcnt_reg <= 16'h0000;
            tick_flag_reg <= 1'b0;
        end else begin
            tcnt_reg <= tcnt_next;
            tick_flag_reg <= tick_flag_next;
        end
    end

    // sequencer state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= ST_RUN;
            vec_reg <= VEC_RESET;
            rc_reg <= 12'h000;
            imask_reg <= 1'b1;
        end else begin
            st_reg <= st_next;
            vec_reg <= vec_next;
            rc_reg <= rc_next;
            imask_reg <= imask_next;
        end
    end

    // fetch and output registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_reg <= VEC_RESET;
            hi_reg <= 8'h00;
            pc_reg <= 16'h0000;
            load_reg <= 1'b0;
            rst_reg <= 1'b0;
            cpuen_reg <= 1'b1;
            sysen_reg <= 1'b1;
        end else begin
            addr_reg <= addr_next;
            hi_reg <= hi_next;
            pc_reg <= pc_next;
            load_reg <= load_next;
            rst_reg <= rst_next;
            cpuen_reg <= cpuen_next;
            sysen_reg <= sysen_next;
        end
    end

    // outputs
    assign prdata = rd_reg;
    assign pready = rdy_reg;
    assign pslverr = err_reg;
    assign mem_addr = addr_reg;
    assign pc_value = pc_reg;
    assign pc_load = load_reg;
    assign sys_rst = rst_reg;
    assign int_mask = imask_reg;
    assign cpu_clk_en = cpuen_reg;
    assign sys_clk_en = sysen_reg;
    assign tick_irq = tick_flag_reg;

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    wait_block_a: assert property (
        setup && hit_tick && in_wait
        |=> pslverr && prdata == 32'h0000_0000)
        else $error("tick register answered in wait");

    stop_block_a: assert property (
        setup && hit_tick && in_stop
        |=> pslverr ##1 $stable(tick_reg))
        else $error("tick register reached in stop");

    tick_frozen_a: assert property (
        in_stop && !osc_run |=> $stable(tcnt_reg))
        else $error("tick ran in stop without oscillator");

    pin_reset_a: assert property (
        rst_pin && in_wait
        |=> st_reg == ST_FETCH_HI && mem_addr == VEC_RESET
        ##1 (mem_addr == 16'hffff || $past(rst_src)))
        else $error("reset pin did not fetch reset vector");

    irq_wake_a: assert property (
        irq_fall && in_stop && !rst_src && !brk_req
        |=> in_rec && vec_reg == 16'hfffa)
        else $error("irq pin did not wake stop");

    recov_long_a: assert property (
        in_stop && st_next == ST_RECOVER && !short_rec
        |=> rc_reg == 12'hfff && !sys_clk_en)
        else $error("long recovery not loaded");

    recov_short_a: assert property (
        in_stop && st_next == ST_RECOVER && short_rec
        |=> rc_reg == 12'h01f)
        else $error("short recovery not loaded");

    entry_mask_a: assert property (
        st_reg == ST_RUN && (wait_req || stop_req) && !rst_src
        |=> !int_mask && !cpu_clk_en)
        else $error("entry did not clear mask");

    pair_order_a: assert property (
        pc_load |-> pc_value == {$past(mem_data, 2), $past(mem_data)})
        else $error("vector bytes assembled wrongly");

endmodule : lpw_wakeup_ctrl

//--- inc/lpw_pkg.sv
/*
 * constants, vector table and carrier type of the low-power wake-up
 * controller; assumes an APB slave at 32-bit data, 12-bit address
 */
package lpw_pkg;

    // register byte offsets
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_TICK = 12'h004;
    localparam logic [11:0] ADDR_STAT = 12'h008;

    // control register fields and reset value
    localparam int CTRL_SHORT_BIT = 0;
    localparam int CTRL_OSC_BIT = 1;
    localparam int CTRL_KPOL_LSB = 8;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;

    // tick register fields and reset value
    localparam int TICK_EN_BIT = 16;
    localparam logic [31:0] TICK_RST = 32'h0000_00ff;

    // status register fields
    localparam int STAT_IMASK_BIT = 4;
    localparam int STAT_PC_LSB = 16;

    // stop recovery in crystal clock cycles
    localparam int RECOV_LONG_CYC = 4096;
    localparam int RECOV_SHORT_CYC = 32;
    localparam logic [11:0] RECOV_LONG_LD = 12'(RECOV_LONG_CYC - 1);
    localparam logic [11:0] RECOV_SHORT_LD = 12'(RECOV_SHORT_CYC - 1);

    // pin synchroniser layout and idle level
    localparam int PIN_W = 10;
    localparam int PIN_RST = 9;
    localparam int PIN_IRQ = 8;
    localparam logic [9:0] PIN_IDLE = 10'h3ff;

    // wake sources, index 0 has highest priority
    localparam int NSRC = 21;
    localparam int SRC_BRK = 0;
    localparam int SRC_IRQ = 1;
    localparam int SRC_KBD = 14;
    localparam int SRC_TICK = 16;
    localparam logic [15:0] VEC_RESET = 16'hfffe;
    localparam logic [15:0] VEC_TAB [NSRC] = '{
        16'hfffc, 16'hfffa, 16'hfff8, 16'hfff6, 16'hfff4, 16'hfff2,
        16'hfff0, 16'hffee, 16'hffec, 16'hffea, 16'hffe8, 16'hffe6,
        16'hffe4, 16'hffe2, 16'hffe0, 16'hffde, 16'hffdc, 16'hffd2,
        16'hffd0, 16'hffce, 16'hffcc};

    // sources that may end stop mode
    localparam logic [20:0] STOP_WAKE = 21'h01_4003;

    // peripheral interrupt requests, levels
    typedef struct packed {
        logic [3:0] t2_hi; // timer two ch5, ch4, ch3, ch2
        logic adc;         // conversion complete
        logic kbd;         // keypad unit request
        logic [2:0] serial; // tx, rx, rx error
        logic [1:0] spi;   // tx, rx
        logic [2:0] t2_lo; // timer two ovf, ch1, ch0
        logic [2:0] t1;    // timer one ovf, ch1, ch0
        logic clk_gen;     // clock generator
        logic brk;         // break
    } lpw_irq_t;

endpackage : lpw_pkg

//--- verif/lpw_vec_rom.sv
/*
 * vector rom model standing beside the wake-up controller;
 * assumes it is read one byte at a time, answering one cycle late
 */
`timescale 1ns/1ps
module lpw_vec_rom (
    input wire logic pclk,            // clock
    input wire logic [15:0] mem_addr, // byte address
    output logic [7:0] mem_data       // byte, one cycle after address
);
    // registered read; content mixes both nibbles so pairs differ
    always_ff @(posedge pclk) begin
        mem_data <= {mem_addr[3:0], mem_addr[7:4]} ^ 8'h5a;
    end
endmodule : lpw_vec_rom

//--- verif/lpw_wakeup_ctrl_tb_top.sv
/*
 * self-checking bench for the wake-up controller: wait wakes per
 * irq_in request, reset sources, stop recovery, keypad edge, tick wake;
 * assumes the vector rom model and a 125 MHz pclk
 */
`timescale 1ns/1ps
module lpw_wakeup_ctrl_tb_top;
    import lpw_pkg::*;
    typedef struct {int src; logic [15:0] vec;} lpw_row_t;
    // request bit of irq_in beside the vector it should fetch
    lpw_row_t rows [19] = '{'{0, 16'hfffc}, '{1, 16'hfff8},
        '{2, 16'hfff6}, '{3, 16'hfff4}, '{4, 16'hfff2}, '{5, 16'hfff0},
        '{6, 16'hffee}, '{7, 16'hffec}, '{8, 16'hffea}, '{9, 16'hffe8},
        '{10, 16'hffe6}, '{11, 16'hffe4}, '{12, 16'hffe2},
        '{13, 16'hffe0}, '{14, 16'hffde}, '{15, 16'hffd2},
        '{16, 16'hffd0}, '{17, 16'hffce}, '{18, 16'hffcc}};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic ext_reset_n, ext_irq_n, emu_mode, wait_req, stop_req;
    logic imask_set, wdog_timeout, uv_reset, err, rst_seen;
    logic [7:0] kbd_pin, mem_data;
    lpw_irq_t irq_in;
    logic [$bits(lpw_irq_t)-1:0] one_hot;
    logic [15:0] mem_addr, pc_value;
    logic pc_load, sys_rst, int_mask, cpu_clk_en, sys_clk_en, tick_irq;
    int fails, tests_run, cyc;

    lpw_wakeup_ctrl u_lpw_wakeup_ctrl (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_reset_n(ext_reset_n),
        .ext_irq_n(ext_irq_n), .kbd_pin(kbd_pin), .emu_mode(emu_mode),
        .wait_req(wait_req), .stop_req(stop_req), .imask_set(imask_set),
        .wdog_timeout(wdog_timeout), .uv_reset(uv_reset),
        .irq_in(irq_in), .mem_data(mem_data), .mem_addr(mem_addr),
        .pc_value(pc_value), .pc_load(pc_load), .sys_rst(sys_rst),
        .int_mask(int_mask), .cpu_clk_en(cpu_clk_en),
        .sys_clk_en(sys_clk_en), .tick_irq(tick_irq));
    lpw_vec_rom u_lpw_vec_rom (.pclk(pclk), .mem_addr(mem_addr),
        .mem_data(mem_data));

    // expected pair: lower address gives the high byte
    function automatic logic [15:0] exp_pc(input logic [15:0] v);
        logic [15:0] w;
        w = v + 16'h0001;
        return {{v[3:0], v[7:4]} ^ 8'h5a, {w[3:0], w[7:4]} ^ 8'h5a};
    endfunction : exp_pc

    task automatic chk(input string name, input logic [31:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out

    // one apb transfer; entered right after a rising edge, and one
    // idle edge follows so the next request never reassigns psel
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // mode request pulse (0 wait, 1 stop), then let it settle
    task automatic req(input int k);
        if (k == 0) wait_req <= 1'b1;
        else stop_req <= 1'b1;
        @(posedge pclk);
        wait_req <= 1'b0;
        stop_req <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask : req

    // wait for the vector load, counting cycles and reset sightings
    task automatic wake(input logic [15:0] vec, input int lim);
        cyc = 0;
        rst_seen = 1'b0;
        do begin
            @(posedge pclk);
            cyc++;
            if (sys_rst === 1'b1) rst_seen = 1'b1;
        end while (pc_load !== 1'b1 && cyc < lim);
        chk("pc_load", 1, pc_load);
        chk("pc_value", {16'h0000, exp_pc(vec)}, {16'h0000, pc_value});
    endtask : wake

    // free-running bus clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // hang guard
    initial begin
        #200000;
        fails++;
        close_out();
    end

    // main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {wait_req, stop_req, imask_set, wdog_timeout, uv_reset} = '0;
        {ext_reset_n, ext_irq_n, emu_mode, kbd_pin} = 11'h7ff;
        irq_in = '0;
        fails = 0;
        tests_run = 0;
        presetn = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("int_mask", 1, int_mask);
        chk("mem_addr", 32'h0000_fffe, mem_addr);
        apb(0, ADDR_TICK, 0);
        chk("tick_rst", TICK_RST, rd);
        apb(0, 12'h00c, 0);
        chk("unmapped", 1, err);
        apb(1, ADDR_STAT, 0);
        chk("stat_wr", 1, err);
        // one wait wake per peripheral source
        for (int i = 0; i < 19; i++) begin
            req(0);
            chk("cpu_clk_en", 0, cpu_clk_en);
            chk("imask_in", 0, int_mask);
            one_hot = '0;
            one_hot[rows[i].src] = 1'b1;
            irq_in <= one_hot;
            wake(rows[i].vec, 20);
            irq_in <= '0;
            chk("imask_out", 0, int_mask);
        end
        imask_set <= 1'b1;
        @(posedge pclk);
        imask_set <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("imask_set", 1, int_mask);
        // tick register blocked in wait, then reset pin ends wait
        req(0);
        apb(0, ADDR_TICK, 0);
        chk("tick_wait", 1, err);
        apb(0, ADDR_STAT, 0);
        chk("stat_wait", 32'h0000_0001, {28'h0, err, rd[2:0]});
        ext_reset_n <= 1'b0;
        repeat (3) @(posedge pclk);
        ext_reset_n <= 1'b1;
        wake(VEC_RESET, 60);
        chk("rst_pin", 1, rst_seen);
        chk("imask_rst", 1, int_mask);
        // watchdog timeout in wait
        req(0);
        wdog_timeout <= 1'b1;
        @(posedge pclk);
        wdog_timeout <= 1'b0;
        wake(VEC_RESET, 40);
        chk("wdog_rst", 1, rst_seen);
        // stop with short and full recovery, woken by irq pin
        for (int s = 1; s >= 0; s--) begin
            apb(1, ADDR_CTRL, s ? 32'h0000_0003 : 32'h0000_0000);
            req(1);
            chk("sys_clk_en", 0, sys_clk_en);
            apb(0, ADDR_TICK, 0);
            chk("tick_stop", 1, err);
            ext_irq_n <= 1'b0;
            wake(16'hfffa, 5000);
            chk("recov_lo", 1, cyc >= (s ? 32 : 4096));
            chk("recov_hi", 1, cyc <= (s ? 44 : 4108));
            chk("sys_clk_on", 1, sys_clk_en);
            ext_irq_n <= 1'b1;
            repeat (5) @(posedge pclk);
        end
        // keypad pin 0 wakes stop on a rising edge
        apb(1, ADDR_CTRL, 32'h0000_0103);
        kbd_pin <= 8'hfe;
        repeat (5) @(posedge pclk);
        req(1);
        kbd_pin <= 8'hff;
        wake(16'hffe0, 200);
        // undervoltage reset ends stop
        req(1);
        uv_reset <= 1'b1;
        @(posedge pclk);
        uv_reset <= 1'b0;
        wake(VEC_RESET, 200);
        chk("uv_rst", 1, rst_seen);
        chk("imask_uv", 1, int_mask);
        // tick rollover wakes stop with oscillator kept running
        apb(1, ADDR_CTRL, 32'h0000_0003);
        apb(1, ADDR_TICK, 32'h0001_000f);
        repeat (20) @(posedge pclk);
        chk("tick_irq", 1, tick_irq);
        req(1);
        wake(16'hffdc, 300);
        apb(1, ADDR_TICK, 0);
        close_out();
    end
endmodule : lpw_wakeup_ctrl_tb_top
